/* File: bench/qws_host.sv */
// Host model that shifts words into the loader
`timescale 1ns/1ns
module qws_host (
    // Clock
    input  wire logic mclk_i,
    // Serial link
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      data_o
);
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        data_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Three mclk per level keeps the serial clock under its ceiling
    task automatic send(input logic [7:0] w);
        sel_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            data_o = w[i];
            tick(3);
            sclk_o = 1'b1;
            tick(3);
            sclk_o = 1'b0;
        end
        data_o = ~data_o;
        sel_n_o = 1'b1;
        tick(3);
    endtask
endmodule

/* File: bench/qws_loader_properties.sv */
// Port assertions for the serial loader
`timescale 1ns/1ns
module qws_loader_properties
    import qws_pkg::*;
(
    // Clock, reset, controls
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       select_n_i,
    input wire logic       midscale_reset_n_i,
    input wire logic       power_down_n_i,
    // Outputs
    input wire logic       serial_out_oe_n_o,
    input wire qws_taps_t  tap_sel_o [NUM_CHANNELS],
    input wire logic [3:0] top_connect_o,
    input wire qws_code_t  wiper_code_latch_o [NUM_CHANNELS]
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_sd_held;
        !power_down_n_i ##1 !power_down_n_i;
    endsequence
    a_midscale_load:
        assert property (!midscale_reset_n_i |=> wiper_code_latch_o[3] == MIDSCALE)
        else $error("no midscale");
    a_sd_taps:
        assert property (!power_down_n_i |=> tap_sel_o[0] == 64'h1) else $error("sd tap");
    a_taps_follow:
        assert property (power_down_n_i |=> tap_sel_o[1] == 64'h1 << $past(wiper_code_latch_o[1]))
        else $error("tap wrong");
    a_code_cause:
        assert property ($changed(wiper_code_latch_o[2]) |->
            $past(select_n_i) || !$past(midscale_reset_n_i)) else $error("stray load");
    a_chain_off:
        assert property (s_sd_held |-> serial_out_oe_n_o) else $error("serial out driven");
    a_chain_clear:
        assert property ((!midscale_reset_n_i && power_down_n_i) ##1 power_down_n_i
            |-> !serial_out_oe_n_o) else $error("serial out kept");
    a_top_follow:
        assert property (top_connect_o == {4{$past(power_down_n_i)}}) else $error("top");
    a_one_tap:
        assert property ($onehot(tap_sel_o[3])) else $error("not one tap");
endmodule
bind qws_loader qws_loader_properties i_qws_loader_properties (.mclk_i, .rst_n_i, .select_n_i,
    .midscale_reset_n_i, .power_down_n_i, .serial_out_oe_n_o, .tap_sel_o, .top_connect_o,
    .wiper_code_latch_o);

/* File: bench/test_quad_wiper_serial_loader.sv */
// Self-checking bench for the serial loader
`timescale 1ns/1ns
module test_quad_wiper_serial_loader;
    import qws_pkg::*;
    logic       mclk = 1'b0, rst_n = 1'b0, mid_n = 1'b1, pd_n = 1'b1;
    logic       sclk, sel_n, ser_in, ser_out, oe_n;
    logic [3:0] top;
    logic [7:0] w;
    qws_taps_t  tap [NUM_CHANNELS];
    qws_code_t  code [NUM_CHANNELS];
    int         n_fail = 0, check_count = 0, seed = 32'hdc3f, ex [4], prev = 0;
    bit         sh_q [$];
    always #10 mclk = ~mclk;
    qws_host i_qws_host (.mclk_i(mclk), .sclk_o(sclk), .sel_n_o(sel_n), .data_o(ser_in));
    qws_loader i_qws_loader (.mclk_i(mclk), .rst_n_i(rst_n), .sclk_i(sclk), .select_n_i(sel_n),
        .serial_in_i(ser_in), .serial_out_o(ser_out), .serial_out_oe_n_o(oe_n), .top_connect_o(top),
        .midscale_reset_n_i(mid_n), .power_down_n_i(pd_n), .tap_sel_o(tap),
        .wiper_code_latch_o(code));
    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t %h %h", $time, e, g);
        end
    endtask
    task automatic chk_all(input int sd);
        for (int c = 0; c < 4; c++) begin
            chk(64'(ex[c]), 64'(code[c]));
            chk(sd ? 64'h1 : 64'h1 << ex[c], tap[c]);
        end
        chk(sd ? 64'h0 : 64'hF, 64'(top));
    endtask
    task automatic summarize;
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (8) sh_q.push_back(1'b0);
        i_qws_host.tick(3);
        rst_n = 1'b1;
        for (int c = 0; c < 4; c++) ex[c] = 32;
        chk_all(0);
        for (int k = 0; k < 14; k++) begin
            w = (k == 0) ? 8'h00 : (k == 1 || k == 12) ? 8'hFF : 8'($random(seed));
            i_qws_host.send(w);
            ex[w[7:6]] = w[5:0];
            // Eight queued bits stand for the serial register; the last one out is on the line
            for (int i = 7; i >= 0; i--) begin
                sh_q.push_back(w[i]);
                prev = sh_q.pop_front();
            end
            chk(64'(prev), 64'(oe_n));
            chk(64'h0, 64'(ser_out));
            chk_all(0);
        end
        pd_n = 1'b0;
        i_qws_host.tick(3);
        chk_all(1);
        chk(64'h1, 64'(oe_n));
        pd_n = 1'b1;
        i_qws_host.tick(3);
        chk_all(0);
        chk(64'(prev), 64'(oe_n));
        mid_n = 1'b0;
        i_qws_host.tick(3);
        mid_n = 1'b1;
        for (int c = 0; c < 4; c++) ex[c] = 32;
        chk_all(0);
        chk(64'h0, 64'(oe_n));
        summarize();
    end
endmodule

/* File: logic/qws_latch_bank.sv */
// Four six-bit wiper code latches with midscale reset
`timescale 1ns/1ns
module qws_latch_bank
    import qws_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         midscale_reset_n_i,
    // Write port
    qws_latch_if.dst          wr,
    // Latched codes
    output qws_code_t         code_o [NUM_CHANNELS]
);
    qws_code_t next_code [NUM_CHANNELS];
    qws_code_t code      [NUM_CHANNELS];

    genvar g;
    generate
        for (g = 0; g < NUM_CHANNELS; g++) begin : g_ch
            always_comb begin
                next_code[g] = code[g];
                if (!midscale_reset_n_i) begin
                    next_code[g] = MIDSCALE;
                end else if (wr.wr_en && wr.wr_addr == 2'(g)) begin
                    next_code[g] = wr.wr_code;
                end
            end
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    code[g] <= MIDSCALE;
                end else begin
                    code[g] <= next_code[g];
                end
            end
            assign code_o[g] = code[g];
        end
    endgenerate
endmodule

/* File: logic/qws_latch_if.sv */
// Write port between the serial front end and the wiper latch bank
`timescale 1ns/1ns
interface qws_latch_if;
    import qws_pkg::*;
    logic       wr_en;
    qws_addr_t  wr_addr;
    qws_code_t  wr_code;
    modport src (output wr_en, output wr_addr, output wr_code);
    modport dst (input  wr_en, input  wr_addr, input  wr_code);
endinterface

/* File: logic/qws_loader.sv */
// Serial loader top: shift register, latch load, tap decode, shutdown
`timescale 1ns/1ns
// What this block does
// - Eight-bit word: two address, six data, MSB first
// - Channel index equals address; data bits five..zero
// - Each channel latch decodes to one-hot tap
// - Code zero bottom tap, 63 top tap
// - Midscale reset loads 32 into all latches
// - Shutdown opens top terminals, wipers to bottom
// - Shutdown keeps latches; release restores taps
// - Each word updates only addressed channel
// - Sample serial input on serial clock rise
// - Select release loads addressed latch
// - Serial output gives bit from eight shifts ago
// - Shutdown releases open-drain serial output
module qws_loader
    import qws_pkg::*;
(
    // Clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        rst_n_i,
    // Serial link (sampled synchronously, host slower than mclk)
    input  wire logic                        sclk_i,
    input  wire logic                        select_n_i,
    input  wire logic                        serial_in_i,
    output logic                             serial_out_o,
    output logic                             serial_out_oe_n_o,
    // Control pins
    input  wire logic                        midscale_reset_n_i,
    input  wire logic                        power_down_n_i,
    // Channel outputs
    output qws_pkg::qws_taps_t               tap_sel_o [qws_pkg::NUM_CHANNELS],
    output logic [qws_pkg::NUM_CHANNELS-1:0] top_connect_o,
    output qws_pkg::qws_code_t               wiper_code_latch_o [qws_pkg::NUM_CHANNELS]
);
    import qws_pkg::*;

    // Front end follows the select pin; one-hot so a stray code is easy to spot
    typedef enum logic [1:0] {
        FRONT_IDLE  = 2'b01,
        FRONT_SHIFT = 2'b10
    } qws_front_t;

    // One-hot tap from code; code zero is the bottom terminal
    function automatic qws_taps_t tap_decode(input qws_code_t c);
        qws_taps_t t;
        t = '0;
        t[c] = 1'b1;
        return t;
    endfunction

    // Pins are synchronous to mclk, so one stored sample is enough to see an edge
    function automatic logic rose(input logic cur_lvl, input logic old_lvl);
        return cur_lvl & ~old_lvl;
    endfunction

    // Channel index carried by the two oldest bits of a word
    function automatic qws_addr_t word_addr(input logic [WORD_BITS-1:0] w);
        return {w[ADDR_HI_POS], w[ADDR_LO_POS]};
    endfunction

    // Wiper code carried by the six newest bits of a word
    function automatic qws_code_t word_code(input logic [WORD_BITS-1:0] w);
        return w[DATA_MSB_POS:0];
    endfunction

    // Sampled pin and front-end state
    logic                    sclk_q;
    logic                    next_sclk_q;
    qws_front_t              front;
    qws_front_t              next_front;
    logic                    sclk_rise;
    logic                    shift_en;
    logic                    load_en;
    // Serial register and daisy-chain bit
    logic [WORD_BITS-1:0]    shreg;
    logic [WORD_BITS-1:0]    next_shreg;
    logic                    chain_bit;
    logic                    next_chain_bit;
    // Latched codes and registered outputs
    qws_code_t               codes     [NUM_CHANNELS];
    qws_taps_t               taps      [NUM_CHANNELS];
    qws_taps_t               next_taps [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] top;
    logic [NUM_CHANNELS-1:0] next_top;

    qws_latch_if lif ();

    // Reset to the idle low level, so leaving reset never looks like a clock edge
    always_comb begin
        next_sclk_q = sclk_i;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= next_sclk_q;
        end
    end

    assign sclk_rise = rose(sclk_i, sclk_q);

    // Shift state is entered on the first edge that sees select low
    always_comb begin
        next_front = front;
        unique case (front)
            FRONT_IDLE: begin
                if (!select_n_i) begin
                    next_front = FRONT_SHIFT;
                end
            end
            FRONT_SHIFT: begin
                if (select_n_i) begin
                    next_front = FRONT_IDLE;
                end
            end
            default: begin
                next_front = FRONT_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            front <= FRONT_IDLE;
        end else begin
            front <= next_front;
        end
    end

    // Midscale reset blocks both shifting and loading while it is held
    assign shift_en = !select_n_i && sclk_rise && midscale_reset_n_i;
    assign load_en  = (front == FRONT_SHIFT) && select_n_i && midscale_reset_n_i;

    always_comb begin
        next_shreg = shreg;
        if (shift_en) begin
            next_shreg = {shreg[WORD_BITS-2:0], serial_in_i};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            shreg <= SHIFT_RESET;
        end else begin
            shreg <= next_shreg;
        end
    end

    // The bit leaving the register is the one entered eight shifts ago
    always_comb begin
        next_chain_bit = chain_bit;
        if (!midscale_reset_n_i) begin
            next_chain_bit = 1'b0;
        end else if (shift_en) begin
            next_chain_bit = shreg[WORD_BITS-1];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            chain_bit <= 1'b0;
        end else begin
            chain_bit <= next_chain_bit;
        end
    end

    // Write goes straight to the latches; a registered request would cost a cycle
    assign lif.wr_en   = load_en;
    assign lif.wr_addr = word_addr(shreg);
    assign lif.wr_code = word_code(shreg);

    qws_latch_bank u_bank (
        .mclk_i             (mclk_i),
        .rst_n_i            (rst_n_i),
        .midscale_reset_n_i (midscale_reset_n_i),
        .wr                 (lif.dst),
        .code_o             (codes)
    );

    // Shutdown only masks the outputs; latches stay untouched
    genvar g;
    generate
        for (g = 0; g < NUM_CHANNELS; g++) begin : g_out
            always_comb begin
                next_taps[g] = tap_decode(codes[g]);
                if (!power_down_n_i) begin
                    next_taps[g] = tap_decode('0);
                end
            end
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    taps[g] <= tap_decode(MIDSCALE);
                end else begin
                    taps[g] <= next_taps[g];
                end
            end
            // Top terminal is open for as long as shutdown is held
            always_comb begin
                next_top[g] = power_down_n_i;
            end
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    top[g] <= 1'b1;
                end else begin
                    top[g] <= next_top[g];
                end
            end
            assign tap_sel_o[g]          = taps[g];
            assign top_connect_o[g]      = top[g];
            assign wiper_code_latch_o[g] = codes[g];
        end
    endgenerate

    // Open drain: pull low only for a zero and never in shutdown
    assign serial_out_o      = 1'b0;
    assign serial_out_oe_n_o = chain_bit | ~power_down_n_i;
endmodule

/* File: logic/qws_pkg.sv */
// Shared constants and types for the quad wiper serial loader
package qws_pkg;
    localparam int          WORD_BITS    = 8;
    localparam int          CODE_BITS    = 6;
    localparam int          NUM_CHANNELS = 4;
    localparam int          NUM_TAPS     = 64;
    localparam int          ADDR_HI_POS  = 7;
    localparam int          ADDR_LO_POS  = 6;
    localparam int          DATA_MSB_POS = 5;
    localparam logic [5:0]  MIDSCALE     = 6'h20;
    localparam logic [7:0]  SHIFT_RESET  = 8'h00;
    localparam real         SCLK_MAX_MHZ = 10.0;
    localparam real         MCLK_MHZ     = 50.0;
    localparam int          MIN_SCLK_CYC = int'(MCLK_MHZ / SCLK_MAX_MHZ);

    typedef logic [CODE_BITS-1:0] qws_code_t;
    typedef logic [1:0]           qws_addr_t;
    typedef logic [NUM_TAPS-1:0]  qws_taps_t;
endpackage
